// >>> rtl/mdma_pkg.sv
// micro dma engine constants, field layouts and carrier types
// Notes on behaviour
// - every transfer request is presented to the cpu at maskable level 6
// - while the cpu is halted, requests stay pending and are not served
// - four channels, each triggered by the source named in its start vector
// - on accept: clear source flag, copy one item, count down by one
// - count left nonzero keeps vector; zero raises end irq and clears vector
// - simultaneous requests are served by channel number, channel 0 first
// - a source with no channel vector goes the ordinary interrupt path
// - end interrupts are arbitrated by the controller like any others
// - address registers are 32 bits, only the low 24 drive the bus
// - items are 1, 2 or 4 bytes; addresses step up, down or hold
// - 16-bit counter; a start value of zero gives 65536 transfers
// - 28 interrupt sources plus the software trigger can start transfers
// - codes 0AH-21H and 29H-2CH trigger; end interrupts never do
// - zero-wait transfer: fetch 3 states, read 2, dummy 1, write 2
// - narrow bus or odd address adds two states to read or write
// - writing one to a software request bit runs one transfer, then clears
// - burst channels keep transferring until their counter reaches zero
// - mode codes 000-100 pick the address stepping, size codes 00-10
// - mode 101 moves no data: source plus one, count down, five states
package mdma_pkg;
  localparam int NCH = 4;
  localparam int ADDR_W = 24;
  localparam logic [7:0] SFR_SWREQ = 8'h89;
  localparam logic [7:0] SFR_BURST = 8'h88;
  localparam logic [7:0] SFR_VEC0 = 8'h80;
  localparam logic [1:0] CR_SRC = 2'h0;
  localparam logic [1:0] CR_DST = 2'h1;
  localparam logic [1:0] CR_CNT = 2'h2;
  localparam logic [1:0] CR_MODE = 2'h3;
  localparam int MODE_LSB = 2;
  localparam int SIZE_LSB = 0;
  localparam logic [2:0] REQ_LEVEL = 3'h6;
  localparam logic [2:0] MD_DINC = 3'h0;
  localparam logic [2:0] MD_DDEC = 3'h1;
  localparam logic [2:0] MD_SINC = 3'h2;
  localparam logic [2:0] MD_SDEC = 3'h3;
  localparam logic [2:0] MD_FIX = 3'h4;
  localparam logic [2:0] MD_COUNT = 3'h5;
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [5:0] VEC_NONE = 6'h00;
  localparam logic [5:0] VEC_LO_A = 6'h0A;
  localparam logic [5:0] VEC_HI_A = 6'h21;
  localparam logic [5:0] VEC_LO_B = 6'h29;
  localparam logic [5:0] VEC_HI_B = 6'h2C;
  localparam logic [2:0] ST_FETCH = 3'h3;
  localparam logic [2:0] ST_READ = 3'h2;
  localparam logic [2:0] ST_WRITE = 3'h1;
  localparam logic [2:0] ST_COUNT = 3'h4;
  localparam logic [2:0] ST_NARROW = 3'h2;
  localparam logic [3:0] RST_BITS = 4'h0;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH = 3'b001,
    S_READ = 3'b011,
    S_GAP = 3'b010,
    S_WRITE = 3'b110,
    S_FINISH = 3'b111,
    S_COUNT = 3'b101
  } dma_state_e;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] cnt;
    logic [7:0] mode;
  } chan_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [1:0] size;
  } rd_cmd_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [1:0] size;
    logic [31:0] data;
  } wr_cmd_s;
endpackage : mdma_pkg

// >>> rtl/micro_dma.sv
// four-channel interrupt-triggered micro dma engine
`timescale 1ns/1ps
`default_nettype none
module micro_dma (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_we,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic cr_we,
  input wire logic [1:0] cr_ch,
  input wire logic [1:0] cr_sel,
  input wire logic [31:0] cr_wdata,
  output logic [31:0] cr_rdata,
  input wire logic [63:0] src_flag,
  output logic [63:0] src_clr,
  output logic [63:0] src_owned,
  input wire logic cpu_halted,
  input wire logic cpu_grant,
  output logic dma_req,
  output logic [2:0] dma_req_level,
  output logic [3:0] done_irq,
  output mdma_pkg::rd_cmd_s rd_cmd,
  output logic rd_req,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [31:0] rd_data,
  input wire logic src_narrow,
  output mdma_pkg::wr_cmd_s wr_cmd,
  output logic wr_valid,
  input wire logic wr_ready,
  input wire logic dst_narrow
);
  import mdma_pkg::*;

  chan_s ch_q [NCH];
  chan_s ch_d [NCH];
  logic [5:0] vec_q [NCH];
  logic [5:0] vec_d [NCH];
  logic [3:0] sw_q, sw_d, burst_q, burst_d;
  dma_state_e st_q, st_d;
  logic [1:0] cur_q, cur_d;
  logic from_sw_q, from_sw_d;
  logic [2:0] tick_q, tick_d;
  logic got_q, got_d, put_q, put_d;
  rd_cmd_s rd_cmd_q, rd_cmd_d;
  logic [ADDR_W-1:0] wa_q, wa_d;
  logic [1:0] wsz_q, wsz_d;
  logic [31:0] fifo_q [2];
  logic [31:0] fifo_d [2];
  logic wp_q, wp_d, rp_q, rp_d;
  logic [1:0] fill_q, fill_d;
  logic [7:0] sfr_rd_q, sfr_rd_d;
  logic [31:0] cr_rd_q, cr_rd_d;
  logic [3:0] pend;
  logic [1:0] pick;
  logic start, fin, cont, push, pop;
  chan_s cc;
  logic [2:0] cmode;
  logic [1:0] csize;
  logic [15:0] cnt_dec;
  logic [2:0] need_rd, need_wr;

  // only listed source codes can trigger
  function automatic logic vec_ok(input logic [5:0] v);
    vec_ok = (v >= VEC_LO_A && v <= VEC_HI_A) ||
             (v >= VEC_LO_B && v <= VEC_HI_B);
  endfunction : vec_ok

  function automatic logic [31:0] step(input logic [1:0] sz);
    if (sz == SZ_BYTE)
      step = 32'h1;
    else if (sz == SZ_WORD)
      step = 32'h2;
    else
      step = 32'h4;
  endfunction : step

  // fields of the channel in service
  assign cc = ch_q[cur_q];
  assign cmode = cc.mode[MODE_LSB +: 3];
  assign csize = cc.mode[SIZE_LSB +: 2];
  // wraps from zero, so zero start gives 65536 runs
  assign cnt_dec = cc.cnt - 16'h1;
  assign cont = burst_q[cur_q] && (cnt_dec != 16'h0);
  // two extra states on narrow bus or odd start
  assign need_rd = ST_READ + ((src_narrow | cc.src[0]) ? ST_NARROW : 3'h0);
  assign need_wr = ST_WRITE + ((dst_narrow | cc.dst[0]) ? ST_NARROW : 3'h0);

  // pending channels and fixed-order pick
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      pend[i] = sw_q[i] | (vec_ok(vec_q[i]) & src_flag[vec_q[i]]);
    pick = 2'h0;
    for (int i = NCH - 1; i >= 0; i--)
      if (pend[i])
        pick = 2'(i);
  end

  // sources not claimed stay ordinary interrupts
  always_comb
  begin
    src_owned = '0;
    for (int i = 0; i < NCH; i++)
      if (vec_ok(vec_q[i]))
        src_owned[vec_q[i]] = 1'b1;
  end

  // no request presented while cpu is halted
  assign dma_req = (|pend) && !cpu_halted && (st_q == S_IDLE);
  assign dma_req_level = dma_req ? REQ_LEVEL : 3'h0;
  assign start = dma_req && cpu_grant;

  // two-entry buffer between read and write phases
  assign rd_ready = (st_q == S_READ) && !got_q && (fill_q != 2'h2);
  assign push = rd_valid && rd_ready;
  assign wr_valid = (st_q == S_WRITE) && !put_q && (fill_q != 2'h0);
  assign pop = wr_valid && wr_ready;
  assign rd_req = (st_q == S_READ) && !got_q;
  assign rd_cmd = rd_cmd_q;
  assign wr_cmd = '{addr: wa_q, size: wsz_q, data: fifo_q[rp_q]};

  always_comb
  begin
    fifo_d = fifo_q;
    wp_d = wp_q;
    rp_d = rp_q;
    fill_d = fill_q;
    if (push)
    begin
      fifo_d[wp_q] = rd_data;
      wp_d = ~wp_q;
    end
    if (pop)
      rp_d = ~rp_q;
    if (push && !pop)
      fill_d = fill_q + 2'h1;
    else if (pop && !push)
      fill_d = fill_q - 2'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fifo_q <= '{default: 32'h0};
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      fill_q <= 2'h0;
    end
    else
    begin
      fifo_q <= fifo_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      fill_q <= fill_d;
    end
  end

  // transfer sequencer; one state per clock
  always_comb
  begin
    st_d = st_q;
    cur_d = cur_q;
    from_sw_d = from_sw_q;
    tick_d = tick_q + 3'h1;
    got_d = got_q | push;
    put_d = put_q | pop;
    rd_cmd_d = rd_cmd_q;
    wa_d = wa_q;
    wsz_d = wsz_q;
    src_clr = '0;
    done_irq = 4'h0;
    fin = 1'b0;
    unique case (st_q)
      S_IDLE:
      begin
        tick_d = 3'h0;
        if (start)
        begin
          cur_d = pick;
          from_sw_d = sw_q[pick];
          if (!sw_q[pick])
            src_clr[vec_q[pick]] = 1'b1;
          if (ch_q[pick].mode[MODE_LSB +: 3] == MD_COUNT)
            st_d = S_COUNT;
          else
            st_d = S_FETCH;
        end
      end
      // fetch cycle, three states
      S_FETCH:
        if (tick_q == ST_FETCH - 3'h1)
        begin
          st_d = S_READ;
          tick_d = 3'h0;
          got_d = 1'b0;
          // only the low 24 bits reach the bus
          rd_cmd_d = '{addr: cc.src[ADDR_W-1:0], size: csize};
        end
      // read holds until both timing and data are in
      S_READ:
        if (tick_q >= need_rd - 3'h1 && (got_q || push))
        begin
          st_d = S_GAP;
          tick_d = 3'h0;
        end
      // dummy state keeps the read address on the bus
      S_GAP:
      begin
        st_d = S_WRITE;
        tick_d = 3'h0;
        put_d = 1'b0;
        wa_d = cc.dst[ADDR_W-1:0];
        wsz_d = csize;
      end
      // a stalled receiver simply stretches this phase
      S_WRITE:
        if (tick_q >= need_wr - 3'h1 && (put_q || pop))
          st_d = S_FINISH;
      S_COUNT:
        if (tick_q == ST_COUNT - 3'h1)
          st_d = S_FINISH;
      S_FINISH:
      begin
        fin = 1'b1;
        tick_d = 3'h0;
        if (cnt_dec == 16'h0)
          done_irq[cur_q] = 1'b1;
        // burst runs on without a new request
        if (cont)
          st_d = (cmode == MD_COUNT) ? S_COUNT : S_FETCH;
        else
          st_d = S_IDLE;
      end
      default:
        st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= S_IDLE;
      cur_q <= 2'h0;
      from_sw_q <= 1'b0;
      tick_q <= 3'h0;
      got_q <= 1'b0;
      put_q <= 1'b0;
      rd_cmd_q <= '0;
      wa_q <= '0;
      wsz_q <= 2'h0;
    end
    else
    begin
      st_q <= st_d;
      cur_q <= cur_d;
      from_sw_q <= from_sw_d;
      tick_q <= tick_d;
      got_q <= got_d;
      put_q <= put_d;
      rd_cmd_q <= rd_cmd_d;
      wa_q <= wa_d;
      wsz_q <= wsz_d;
    end
  end

  // channel settings; software writes land last so they win
  always_comb
  begin
    ch_d = ch_q;
    vec_d = vec_q;
    sw_d = sw_q;
    burst_d = burst_q;
    if (fin)
    begin
      // count down by one per item
      ch_d[cur_q].cnt = cnt_dec;
      unique case (cmode)
        MD_DINC: ch_d[cur_q].dst = cc.dst + step(csize);
        MD_DDEC: ch_d[cur_q].dst = cc.dst - step(csize);
        MD_SINC: ch_d[cur_q].src = cc.src + step(csize);
        MD_SDEC: ch_d[cur_q].src = cc.src - step(csize);
        MD_COUNT: ch_d[cur_q].src = cc.src + 32'h1;
        default: ;
      endcase
      if (cnt_dec == 16'h0)
        vec_d[cur_q] = VEC_NONE;
      // software request bit drops at the end
      if (from_sw_q && !cont)
        sw_d[cur_q] = 1'b0;
    end
    if (cr_we)
      unique case (cr_sel)
        CR_SRC: ch_d[cr_ch].src = cr_wdata;
        CR_DST: ch_d[cr_ch].dst = cr_wdata;
        CR_CNT: ch_d[cr_ch].cnt = cr_wdata[15:0];
        CR_MODE: ch_d[cr_ch].mode = cr_wdata[7:0];
      endcase
    if (sfr_we)
    begin
      if (sfr_addr == SFR_SWREQ)
        sw_d = sfr_wdata[3:0];
      else if (sfr_addr == SFR_BURST)
        burst_d = sfr_wdata[3:0];
      else if (sfr_addr[7:2] == SFR_VEC0[7:2])
        vec_d[sfr_addr[1:0]] = sfr_wdata[5:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ch_q <= '{default: '0};
      vec_q <= '{default: VEC_NONE};
      sw_q <= RST_BITS;
      burst_q <= RST_BITS;
    end
    else
    begin
      ch_q <= ch_d;
      vec_q <= vec_d;
      sw_q <= sw_d;
      burst_q <= burst_d;
    end
  end

  // registered read-back, one clock after the address
  always_comb
  begin
    sfr_rd_d = 8'h00;
    if (sfr_addr == SFR_SWREQ)
      sfr_rd_d = {4'h0, sw_q};
    else if (sfr_addr == SFR_BURST)
      sfr_rd_d = {4'h0, burst_q};
    else if (sfr_addr[7:2] == SFR_VEC0[7:2])
      sfr_rd_d = {2'h0, vec_q[sfr_addr[1:0]]};
    unique case (cr_sel)
      CR_SRC: cr_rd_d = ch_q[cr_ch].src;
      CR_DST: cr_rd_d = ch_q[cr_ch].dst;
      CR_CNT: cr_rd_d = {16'h0, ch_q[cr_ch].cnt};
      CR_MODE: cr_rd_d = {24'h0, ch_q[cr_ch].mode};
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sfr_rd_q <= 8'h00;
      cr_rd_q <= 32'h0;
    end
    else
    begin
      sfr_rd_q <= sfr_rd_d;
      cr_rd_q <= cr_rd_d;
    end
  end

  assign sfr_rdata = sfr_rd_q;
  assign cr_rdata = cr_rd_q;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence fetch_phase;
    st_q == S_FETCH [*3];
  endsequence
  sequence read_entry;
    st_q == S_READ;
  endsequence

  AST_LEVEL6: assert property (dma_req |-> dma_req_level == REQ_LEVEL)
    else $error("request not at level six");
  AST_HALT_HOLD: assert property (
    cpu_halted && st_q == S_IDLE |=> st_q == S_IDLE)
    else $error("transfer started while halted");
  AST_CH0_FIRST: assert property (start && pend[0] |=> cur_q == 2'h0)
    else $error("channel zero not served first");
  AST_FLAG_CLR: assert property (
    start && !sw_q[pick] |-> src_clr[vec_q[pick]])
    else $error("source flag not cleared");
  AST_CNT_DOWN: assert property (
    fin && !cr_we |=> ch_q[$past(cur_q)].cnt == $past(cnt_dec))
    else $error("counter did not drop by one");
  // end irq exactly at last item
  AST_END_IRQ: assert property (
    fin |-> done_irq[cur_q] == (cc.cnt == 16'h1))
    else $error("end interrupt misplaced");
  AST_FETCH3: assert property (
    $rose(st_q == S_FETCH) |-> fetch_phase ##1 read_entry)
    else $error("fetch phase not three states");
  AST_COUNT5: assert property (
    $rose(st_q == S_COUNT) |-> st_q == S_COUNT [*4] ##1 st_q == S_FINISH)
    else $error("counting mode not five states");
  AST_SW_CLR: assert property (
    fin && from_sw_q && !cont && !sfr_we |=> !sw_q[$past(cur_q)])
    else $error("software request bit not cleared");
  AST_BURST: assert property (
    fin && cont |=> st_q == S_FETCH || st_q == S_COUNT)
    else $error("burst stopped early");
  AST_IDLE_CH: assert property (
    start |-> sw_q[pick] || vec_q[pick] != VEC_NONE)
    else $error("idle channel triggered");
endmodule : micro_dma
`default_nettype wire

// >>> tb/bus_mem.sv
// memory and i/o bus model on the engine's far side
`timescale 1ns/1ps
`default_nettype none
module bus_mem (
  input wire logic mclk,
  input wire mdma_pkg::rd_cmd_s rd_cmd,
  input wire logic rd_req,
  input wire logic rd_ready,
  output logic rd_valid,
  output logic [31:0] rd_data,
  input wire mdma_pkg::wr_cmd_s wr_cmd,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [1:0] lat
);
  import mdma_pkg::*;
  logic [7:0] mem [0:255];
  logic [1:0] rw_q = 2'h0;
  logic [1:0] ww_q = 2'h0;
  logic [31:0] last_q = 32'h0;
  logic [7:0] a;
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h00;
  end
  // lat cycles of stall before each answer
  assign rd_valid = rd_req && rw_q >= lat;
  assign wr_ready = wr_valid && ww_q >= lat;
  assign a = rd_cmd.addr[7:0];
  // idle data is inverted so stale values never look right
  assign rd_data = rd_valid ?
    {mem[a + 8'h3], mem[a + 8'h2], mem[a + 8'h1], mem[a]} : ~last_q;
  // wait counters and byte writes by item size
  always @(posedge mclk)
  begin
    rw_q <= (rd_req && !rd_valid) ? rw_q + 2'h1 : 2'h0;
    ww_q <= (wr_valid && !wr_ready) ? ww_q + 2'h1 : 2'h0;
    if (rd_valid && rd_ready)
      last_q <= rd_data;
    if (wr_valid && wr_ready)
      for (int i = 0; i < 4; i++)
        if (i < (1 << wr_cmd.size))
          mem[wr_cmd.addr[7:0] + 8'(i)] <= wr_cmd.data[8*i +: 8];
  end
endmodule : bus_mem
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the micro dma engine
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mdma_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic sfr_we = 1'b0, cr_we = 1'b0, cpu_halted = 1'b0, cpu_grant = 1'b1;
  logic src_narrow = 1'b0, dst_narrow = 1'b0, dma_req, rd_req, rd_valid;
  logic rd_ready, wr_valid, wr_ready;
  logic [1:0] cr_ch = 2'h0, cr_sel = 2'h0, lat = 2'h0;
  logic [31:0] cr_wdata = 32'h0, cr_rdata, rd_data;
  logic [63:0] src_flag = 64'h0, flag_set = 64'h0, src_clr, src_owned;
  logic [63:0] first_clr = 64'h0;
  logic [2:0] dma_req_level;
  logic [3:0] done_irq, done_acc = 4'h0;
  logic [23:0] rd_last = 24'h0;
  rd_cmd_s rd_cmd;
  wr_cmd_s wr_cmd;
  int num_errors = 0, n_checks = 0, cyc = 0, t_grant = 0, t_done = 0;
  int n_wr = 0;

  micro_dma u_dut (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_we(sfr_we), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cr_we(cr_we), .cr_ch(cr_ch), .cr_sel(cr_sel), .cr_wdata(cr_wdata),
    .cr_rdata(cr_rdata), .src_flag(src_flag), .src_clr(src_clr),
    .src_owned(src_owned), .cpu_halted(cpu_halted), .cpu_grant(cpu_grant),
    .dma_req(dma_req), .dma_req_level(dma_req_level), .done_irq(done_irq),
    .rd_cmd(rd_cmd), .rd_req(rd_req), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .src_narrow(src_narrow),
    .wr_cmd(wr_cmd), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .dst_narrow(dst_narrow));
  bus_mem u_mem (.mclk(mclk), .rd_cmd(rd_cmd), .rd_req(rd_req),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_cmd(wr_cmd), .wr_valid(wr_valid), .wr_ready(wr_ready), .lat(lat));

  always #50 mclk = ~mclk;
  // event monitor; flags clear on the engine's pulse
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (dma_req && cpu_grant) t_grant <= cyc;
    if (|done_irq) t_done <= cyc;
    done_acc <= done_acc | done_irq;
    if (|src_clr && first_clr == 64'h0) first_clr <= src_clr;
    if (wr_valid && wr_ready) n_wr <= n_wr + 1;
    if (rd_valid && rd_ready) rd_last <= rd_cmd.addr;
    src_flag <= (src_flag & ~src_clr) | flag_set;
  end

  task automatic chk(input string w, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'b1;
    tick(1);
    sfr_we = 1'b0;
    // idle cycle so a following write never re-raises the strobe at once
    tick(1);
  endtask : sfr_wr
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    tick(1);
    d = sfr_rdata;
  endtask : sfr_rd
  task automatic cr_wr(input logic [1:0] c, s, input logic [31:0] d);
    cr_ch = c;
    cr_sel = s;
    cr_wdata = d;
    cr_we = 1'b1;
    tick(1);
    cr_we = 1'b0;
    // idle cycle so a following write never re-raises the strobe at once
    tick(1);
  endtask : cr_wr
  task automatic cr_rd(input logic [1:0] c, s, output logic [31:0] d);
    cr_ch = c;
    cr_sel = s;
    tick(1);
    d = cr_rdata;
  endtask : cr_rd
  task automatic setup(input logic [1:0] c, input logic [31:0] s, d, n,
    input logic [7:0] m);
    cr_wr(c, CR_SRC, s);
    cr_wr(c, CR_DST, d);
    cr_wr(c, CR_CNT, n);
    cr_wr(c, CR_MODE, {24'h0, m});
  endtask : setup
  task automatic kick(input int c);
    logic [7:0] b;
    b = 8'hFF;
    for (int i = 0; i < 50 && b[c]; i++)
      sfr_rd(SFR_SWREQ, b);
    sfr_wr(SFR_SWREQ, 8'(1 << c));
  endtask : kick
  task automatic wait_cnt(input logic [1:0] c, input logic [31:0] e);
    logic [31:0] v;
    v = ~e;
    for (int i = 0; i < 100 && v !== e; i++)
      cr_rd(c, CR_CNT, v);
    chk("count", e, v);
  endtask : wait_cnt
  task automatic raise(input logic [63:0] m);
    flag_set = m;
    tick(1);
    flag_set = 64'h0;
  endtask : raise

  task automatic t_idle;
    logic [7:0] v;
    sfr_rd(SFR_SWREQ, v);
    chk("swreq reset", 8'h00, v);
    sfr_wr(SFR_VEC0 + 8'h1, 8'h22);
    raise(64'h1 << 8'h22);
    tick(4);
    chk("idle req", 1'b0, dma_req);
    chk("owned 22h", 1'b0, src_owned[8'h22]);
  endtask : t_idle
  task automatic t_sw;
    logic [31:0] v;
    logic [7:0] b;
    u_mem.mem[8'h10] = 8'hA5;
    done_acc = 4'h0;
    setup(2'h0, 32'hFF000010, 32'h20, 32'h1, {3'h0, MD_DINC, SZ_BYTE});
    cpu_grant = 1'b0;
    kick(0);
    tick(3);
    chk("req lvl", {1'b1, REQ_LEVEL}, {dma_req, dma_req_level});
    cpu_grant = 1'b1;
    wait_cnt(2'h0, 32'h0);
    chk("byte", 8'hA5, u_mem.mem[8'h20]);
    chk("rd addr", 24'h10, rd_last);
    cr_rd(2'h0, CR_DST, v);
    chk("dst", 32'h21, v);
    sfr_rd(SFR_SWREQ, b);
    chk("sw bit", 8'h00, b);
    chk("states", 8, t_done - t_grant);
    chk("end irq", 4'h1, done_acc);
  endtask : t_sw
  task automatic t_timing;
    logic [31:0] v;
    int w;
    for (int k = 0; k < 3; k++)
    begin
      src_narrow = (k < 2);
      dst_narrow = (k == 1);
      w = n_wr;
      setup(2'h0, 32'h40, 32'h50, 32'h1,
        {3'h0, (k == 2) ? MD_COUNT : MD_SINC, SZ_BYTE});
      kick(0);
      wait_cnt(2'h0, 32'h0);
      chk("states", k == 2 ? 5 : 10 + 2 * k, t_done - t_grant);
      cr_rd(2'h0, CR_SRC, v);
      chk("src", 32'h41, v);
      chk("writes", k < 2, n_wr - w);
    end
    src_narrow = 1'b0;
    dst_narrow = 1'b0;
  endtask : t_timing
  task automatic t_modes;
    logic [31:0] s, d;
    int st;
    // slow far side for modes 000-100
    lat = 2'h2;
    for (int m = 0; m < 5; m++)
    begin
      st = 1 << (m % 3);
      u_mem.mem[8'h80] = 8'(m + 8'h30);
      setup(2'h1, 32'h80, 32'hC0, 32'h9, {3'h0, 3'(m), 2'(m % 3)});
      kick(1);
      wait_cnt(2'h1, 32'h8);
      cr_rd(2'h1, CR_SRC, s);
      cr_rd(2'h1, CR_DST, d);
      chk("src", m == 2 ? 32'h80 + st : m == 3 ? 32'h80 - st : 32'h80,
        s);
      chk("dst", m == 0 ? 32'hC0 + st : m == 1 ? 32'hC0 - st : 32'hC0,
        d);
      chk("data", 8'(m + 8'h30), u_mem.mem[8'hC0]);
    end
    lat = 2'h0;
  endtask : t_modes
  task automatic t_irq;
    logic [7:0] v;
    done_acc = 4'h0;
    setup(2'h2, 32'h10, 32'h30, 32'h1, {3'h0, MD_FIX, SZ_BYTE});
    // trigger-only source, its ordinary level is left at zero
    // the shared source is an edge pulse from the flag model
    sfr_wr(SFR_VEC0 + 8'h2, 8'h0D);
    chk("owned", 1'b1, src_owned[8'h0D]);
    raise(64'h1 << 8'h0D);
    wait_cnt(2'h2, 32'h0);
    chk("flag clr", 1'b0, src_flag[8'h0D]);
    chk("end irq", 4'h4, done_acc);
    sfr_rd(SFR_VEC0 + 8'h2, v);
    chk("vec clr", 8'h00, v);
    chk("unowned", 1'b0, src_owned[8'h0D]);
    raise(64'h1 << 8'h0D);
    tick(10);
    chk("no rerun", 1'b1, src_flag[8'h0D]);
  endtask : t_irq
  task automatic t_prio;
    setup(2'h1, 32'h10, 32'h70, 32'h2, {3'h0, MD_FIX, SZ_BYTE});
    setup(2'h3, 32'h10, 32'h78, 32'h2, {3'h0, MD_FIX, SZ_BYTE});
    sfr_wr(SFR_VEC0 + 8'h3, 8'h21);
    sfr_wr(SFR_VEC0 + 8'h1, 8'h29);
    cpu_grant = 1'b0;
    first_clr = 64'h0;
    raise((64'h1 << 8'h21) | (64'h1 << 8'h29));
    tick(2);
    cpu_grant = 1'b1;
    wait_cnt(2'h3, 32'h1);
    wait_cnt(2'h1, 32'h1);
    chk("ch1 first", 1'b1, first_clr === (64'h1 << 8'h29));
  endtask : t_prio
  task automatic t_halt;
    logic [31:0] v;
    setup(2'h0, 32'h10, 32'h20, 32'h3, {3'h0, MD_DINC, SZ_BYTE});
    cpu_halted = 1'b1;
    kick(0);
    tick(6);
    chk("halt req", 1'b0, dma_req);
    cr_rd(2'h0, CR_CNT, v);
    chk("halt cnt", 32'h3, v);
    cpu_halted = 1'b0;
    wait_cnt(2'h0, 32'h2);
  endtask : t_halt
  task automatic t_burst;
    int w;
    w = n_wr;
    done_acc = 4'h0;
    setup(2'h0, 32'h10, 32'h60, 32'h3, {3'h0, MD_DINC, SZ_BYTE});
    sfr_wr(SFR_BURST, 8'h01);
    kick(0);
    wait_cnt(2'h0, 32'h0);
    chk("burst wr", 3, n_wr - w);
    chk("burst end", 4'h1, done_acc);
    sfr_wr(SFR_BURST, 8'h00);
    done_acc = 4'h0;
    setup(2'h0, 32'h10, 32'h60, 32'h0, {3'h0, MD_DINC, SZ_BYTE});
    kick(0);
    wait_cnt(2'h0, 32'hFFFF);
    chk("no end", 4'h0, done_acc);
  endtask : t_burst

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // main sequence after 12 cycles of reset
  initial
  begin
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    t_idle;
    t_sw;
    t_timing;
    t_modes;
    t_irq;
    t_prio;
    t_halt;
    t_burst;
    end_of_test;
  end
  // watchdog well past the few hundred cycles needed
  initial
  begin
    #2000000;
    num_errors++;
    $display("CHECK FAILED watchdog expected end seen hang");
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
